//--- core/usbm_endpoint_ram_manager.sv
// endpoint configuration, packet ram allocation, window aliasing and dma burst sizing
// assumes an apb master on pclk; packet, window and dma strobes come from logic on pclk;
// only the end-of-bus-reset event arrives from the transceiver domain
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module usbm_endpoint_ram_manager (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_reset_end,
  input wire usbm_pkg::usbm_win_t win,
  input wire logic [usbm_pkg::NUM_EP-1:0] tx_sent,
  input wire logic [usbm_pkg::NUM_EP-1:0] rx_stored,
  input wire logic [2:0] dma_ep,
  input wire logic dma_start,
  input wire logic [31:0] dma_start_addr,
  input wire logic dma_beat,
  output logic device_port_enable,
  output logic [usbm_pkg::NUM_EP-1:0] ep_active,
  output logic [usbm_pkg::NUM_EP-1:0] endpoint_mapped_flag,
  output logic [11:0] packet_ram_addr,
  output logic [usbm_pkg::NUM_EP-1:0] bank_validate,
  output logic [usbm_pkg::NUM_EP-1:0] packet_event,
  output logic [31:0] dma_addr,
  output logic [8:0] dma_burst_words
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    usbm_pkg::usbm_cfg_t [usbm_pkg::NUM_EP-1:0] cfg;
    usbm_pkg::usbm_ctl_t [usbm_pkg::NUM_EP-1:0] ctl;
    usbm_pkg::usbm_dma_t [usbm_pkg::NUM_EP-1:0] dma;
    logic [usbm_pkg::NUM_EP-1:0][12:0] base;
    logic [usbm_pkg::NUM_EP-1:0] mapped;
    logic [usbm_pkg::NUM_EP-1:0] active;
    logic ep0_live;
    logic port_en;
    logic [2:0] rst_sync;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [11:0] ram_addr;
    logic [usbm_pkg::NUM_EP-1:0] validate;
    logic [usbm_pkg::NUM_EP-1:0] event_pulse;
    logic [31:0] dma_addr;
    logic [8:0] burst;
  } usbm_state_t;

  usbm_state_t s;
  usbm_state_t next_s;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [12:0] usbm_size_bytes(input logic [2:0] code);
    usbm_size_bytes = usbm_pkg::MIN_EP_BYTES << code;
  endfunction

  function automatic logic [12:0] usbm_alloc_bytes(input usbm_pkg::usbm_cfg_t c);
    logic [14:0] prod;
    prod = 15'(c.bank_count_field) * 15'(usbm_size_bytes(c.endpoint_size_field));
    usbm_alloc_bytes = prod[12:0];
  endfunction

  function automatic logic usbm_ep_hit(input logic [11:0] a);
    usbm_ep_hit = (a[11:8] == usbm_pkg::EP_PAGE) && (32'(a[7:5]) < usbm_pkg::NUM_EP) && (a[1:0] == 2'h0);
  endfunction

  // fit check for one endpoint against its own limits
  function automatic logic usbm_fits(input usbm_pkg::usbm_cfg_t c, input logic [1:0] max_banks, input logic ep0);
    logic ok;
    ok = (c.bank_count_field != 2'h0) && (c.bank_count_field <= max_banks);
    if (c.endpoint_type_field == usbm_pkg::USBM_CONTROL) begin
      ok = ok && (c.bank_count_field == usbm_pkg::CTRL_BANKS);
    end
    if (ep0) begin
      ok = ok && (c.endpoint_size_field <= usbm_pkg::EP0_MAX_SIZE_CODE);
    end
    usbm_fits = ok;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  logic [2:0] widx;
  logic [2:0] ridx;
  logic [2:0] ep_reg;
  usbm_pkg::usbm_cfg_t new_cfg;
  logic [14:0] demand;
  logic [12:0] new_alloc;
  logic [12:0] prev_end;
  logic [12:0] win_alloc;
  logic [12:0] win_size;
  logic [15:0] win_phys;
  logic [15:0] ep_words;
  logic [15:0] len_words;
  logic [15:0] cap_words;
  logic [15:0] burst_words;
  logic old_alloc;
  logic now_alloc;

  always_comb begin
    next_s = s;
    widx = paddr[7:5];
    ridx = paddr[7:5];
    ep_reg = paddr[4:2];
    new_cfg = usbm_pkg::usbm_cfg_t'(pwdata[$bits(usbm_pkg::usbm_cfg_t)-1:0]);
    demand = 15'h0000;
    new_alloc = 13'h0000;
    prev_end = 13'h0000;
    win_alloc = 13'h0000;
    win_size = 13'h0000;
    win_phys = 16'h0000;
    ep_words = 16'h0000;
    len_words = 16'h0000;
    cap_words = 16'h0000;
    burst_words = 16'h0000;
    old_alloc = 1'b0;
    now_alloc = 1'b0;
    next_s.validate = '0;
    next_s.event_pulse = '0;

    // ****************************************
    // bus reset end synchroniser
    // ****************************************
    // only the second and third stages are looked at; the third holds its old value for edge detection
    next_s.rst_sync = {s.rst_sync[1], s.rst_sync[0], bus_reset_end};

    // ****************************************
    // register bus and allocation
    // ****************************************
    // apb: answer in the access cycle, zero wait states
    if (psel && !penable) begin
      next_s.pready = 1'b1;
      next_s.pslverr = 1'b0;
      next_s.prdata = 32'h0000_0000;
      if (paddr == usbm_pkg::ADDR_PORT_CTRL) begin
        next_s.prdata = {31'h0, s.port_en};
      end else if (usbm_ep_hit(paddr)) begin
        case (ep_reg)
          usbm_pkg::EP_CFG: next_s.prdata = {s.mapped[ridx], 21'h0, s.cfg[ridx]};
          usbm_pkg::EP_CTL_ENABLE, usbm_pkg::EP_CTL_DISABLE: next_s.prdata = 32'h0000_0000;
          usbm_pkg::EP_CTL: next_s.prdata = {27'h0, s.active[ridx], s.ctl[ridx]};
          usbm_pkg::EP_DMA: next_s.prdata = s.dma[ridx];
          default: next_s.pslverr = 1'b1;
        endcase
      end else begin
        next_s.pslverr = 1'b1;
      end
    end else if (psel && penable && s.pready) begin
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
      if (pwrite && !s.pslverr) begin
        if (paddr == usbm_pkg::ADDR_PORT_CTRL) begin
          next_s.port_en = pwdata[0];
        end else begin
          case (ep_reg)
            usbm_pkg::EP_CFG: begin
              if (widx == 3'h0) begin
                new_cfg.endpoint_type_field = usbm_pkg::USBM_CONTROL;
              end
              old_alloc = (s.cfg[widx].bank_count_field != 2'h0);
              now_alloc = (new_cfg.bank_count_field != 2'h0);
              new_alloc = usbm_alloc_bytes(new_cfg);
              if (widx != 3'h0) begin
                prev_end = s.base[widx-3'h1] + usbm_alloc_bytes(s.cfg[widx-3'h1]);
              end
              // total demand up to and including this endpoint; overlaps are not looked at
              for (int i = 0; i < usbm_pkg::NUM_EP; i++) begin
                if (i < 32'(widx)) begin
                  demand = demand + 15'(usbm_alloc_bytes(s.cfg[i]));
                end
              end
              demand = demand + 15'(new_alloc);
              next_s.cfg[widx] = new_cfg;
              next_s.mapped[widx] = usbm_fits(new_cfg, usbm_pkg::MAX_BANKS[widx], widx == 3'h0)
                                    && (demand <= usbm_pkg::RAM_BYTES);
              // only this endpoint and the one above move; lower ones never do
              if (now_alloc) begin
                next_s.base[widx] = prev_end;
                if (32'(widx) < usbm_pkg::NUM_EP - 1) begin
                  next_s.base[widx+3'h1] = prev_end + new_alloc;
                end
              end else if (old_alloc) begin
                next_s.mapped[widx] = 1'b0;
                if (32'(widx) < usbm_pkg::NUM_EP - 1) begin
                  next_s.base[widx+3'h1] = s.base[widx];
                end
              end
            end
            usbm_pkg::EP_CTL_ENABLE: begin
              next_s.ctl[widx] = s.ctl[widx] | usbm_pkg::usbm_ctl_t'(pwdata[3:0]);
            end
            usbm_pkg::EP_CTL_DISABLE: begin
              // configuration and ram area are left alone
              next_s.ctl[widx] = s.ctl[widx] & ~usbm_pkg::usbm_ctl_t'(pwdata[3:0]);
            end
            usbm_pkg::EP_DMA: next_s.dma[widx] = usbm_pkg::usbm_dma_t'(pwdata);
            default: next_s.port_en = s.port_en;
          endcase
        end
      end
    end

    // ****************************************
    // endpoint activity and packet events
    // ****************************************
    // endpoint 0 goes live only at the end of bus reset, and only if ready then
    if (s.rst_sync[1] && !s.rst_sync[2]) begin
      next_s.ep0_live = s.ctl[0].endpoint_enable_bit && s.mapped[0];
    end else if (!s.ctl[0].endpoint_enable_bit) begin
      next_s.ep0_live = 1'b0;
    end
    for (int i = 0; i < usbm_pkg::NUM_EP; i++) begin
      if (i == 0) begin
        next_s.active[i] = s.port_en && s.ep0_live;
      end else begin
        next_s.active[i] = s.port_en && s.ctl[i].endpoint_enable_bit && s.mapped[i];
      end
      // status stages raise the same per-packet events as data stages
      if (s.active[i] && !s.dma[i].channel_enable) begin
        next_s.event_pulse[i] = (tx_sent[i] && s.ctl[i].tx_packet_ready)
                              || (rx_stored[i] && s.ctl[i].rx_packet_ready);
      end
    end

    // ****************************************
    // logical window
    // ****************************************
    // window: the physical block repeats over the whole 64 KB offset range
    // an endpoint number past the last one reads as unallocated, never as unknown
    if (32'(win.ep) < usbm_pkg::NUM_EP) begin
      win_alloc = usbm_alloc_bytes(s.cfg[win.ep]);
      win_size = usbm_size_bytes(s.cfg[win.ep].endpoint_size_field);
    end
    if (win_alloc != 13'h0000) begin
      win_phys = 16'(s.base[win.ep]) + (win.offset % 16'(win_alloc));
      // a write of the last byte of a bank hands the bank over
      if (win.write && s.ctl[win.ep].auto_valid && s.active[win.ep]
          && ((win.offset % 16'(win_size)) == 16'(win_size - 13'h0001))) begin
        next_s.validate[win.ep] = 1'b1;
      end
    end
    next_s.ram_addr = win_phys[11:0];

    // ****************************************
    // dma burst and address
    // ****************************************
    // dma burst length is the least of type cap, endpoint size and buffer length
    // an endpoint number past the last one gives a zero burst
    if (32'(dma_ep) < usbm_pkg::NUM_EP) begin
      ep_words = 16'(usbm_size_bytes(s.cfg[dma_ep].endpoint_size_field) >> 2);
      len_words = (s.dma[dma_ep].buff_length >> 2) + 16'(s.dma[dma_ep].buff_length[1:0] != 2'h0);
      cap_words = (s.cfg[dma_ep].endpoint_type_field == usbm_pkg::USBM_ISO) ?
                  16'(usbm_pkg::BURST_CAP_ISO) : 16'(usbm_pkg::BURST_CAP_BULK);
    end
    burst_words = (ep_words < len_words) ? ep_words : len_words;
    if (cap_words < burst_words) begin
      burst_words = cap_words;
    end
    next_s.burst = burst_words[8:0];
    if (dma_start) begin
      next_s.dma_addr = dma_start_addr;
    end else if (dma_beat) begin
      next_s.dma_addr = s.dma_addr + 32'(usbm_pkg::ADDR_BYTE_STEP);
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign device_port_enable = s.port_en;
  assign ep_active = s.active;
  assign endpoint_mapped_flag = s.mapped;
  assign packet_ram_addr = s.ram_addr;
  assign bank_validate = s.validate;
  assign packet_event = s.event_pulse;
  assign dma_addr = s.dma_addr;
  assign dma_burst_words = s.burst;

endmodule

`default_nettype wire

//--- core/usbm_pkg.sv
// constants, register map and carrier types of the endpoint ram manager
// assumes a 32-bit apb slave clocked by pclk at 20 MHz
package usbm_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int NUM_EP = 7;
  localparam logic [14:0] RAM_BYTES = 15'h1000;
  localparam logic [12:0] MIN_EP_BYTES = 13'h0008;
  localparam logic [2:0] EP0_MAX_SIZE_CODE = 3'h3;
  localparam logic [8:0] BURST_CAP_BULK = 9'h080;
  localparam logic [8:0] BURST_CAP_ISO = 9'h100;
  localparam logic [13:0] ADDR_BYTE_STEP = 14'h0004;
  localparam logic [1:0] CTRL_BANKS = 2'h1;
  // allowed banks per endpoint, endpoint 0 in the low slot
  localparam logic [NUM_EP-1:0][1:0] MAX_BANKS = {2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h2, 2'h1};

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [11:0] ADDR_PORT_CTRL = 12'h000;
  localparam logic [3:0] EP_PAGE = 4'h1;
  localparam logic [2:0] EP_CFG = 3'h0;
  localparam logic [2:0] EP_CTL_ENABLE = 3'h1;
  localparam logic [2:0] EP_CTL_DISABLE = 3'h2;
  localparam logic [2:0] EP_CTL = 3'h3;
  localparam logic [2:0] EP_DMA = 3'h4;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    USBM_CONTROL,
    USBM_ISO,
    USBM_BULK,
    USBM_INTERRUPT
  } usbm_type_t;

  typedef struct packed {
    logic [1:0] transactions_per_microframe;
    logic [1:0] bank_count_field;
    usbm_type_t endpoint_type_field;
    logic endpoint_direction_field;
    logic [2:0] endpoint_size_field;
  } usbm_cfg_t;

  typedef struct packed {
    logic rx_packet_ready;
    logic tx_packet_ready;
    logic auto_valid;
    logic endpoint_enable_bit;
  } usbm_ctl_t;

  typedef struct packed {
    logic [15:0] buff_length;
    logic [14:0] unused;
    logic channel_enable;
  } usbm_dma_t;

  typedef struct packed {
    logic [2:0] ep;
    logic [15:0] offset;
    logic write;
  } usbm_win_t;

endpackage

//--- dv/usbm_endpoint_ram_manager_props.sv
// checker for the endpoint ram manager ports
// assumes binding onto the design top, single pclk domain
`timescale 1ns/1ps
`default_nettype none

module usbm_endpoint_ram_manager_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire usbm_pkg::usbm_win_t win,
  input wire logic [usbm_pkg::NUM_EP-1:0] tx_sent,
  input wire logic [usbm_pkg::NUM_EP-1:0] rx_stored,
  input wire logic dma_start,
  input wire logic [31:0] dma_start_addr,
  input wire logic dma_beat,
  input wire logic [usbm_pkg::NUM_EP-1:0] ep_active,
  input wire logic [usbm_pkg::NUM_EP-1:0] endpoint_mapped_flag,
  input wire logic [usbm_pkg::NUM_EP-1:0] bank_validate,
  input wire logic [usbm_pkg::NUM_EP-1:0] packet_event,
  input wire logic [31:0] dma_addr,
  input wire logic [8:0] dma_burst_words
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready) else $error("ready held too long");
  a_slverr_ready: assert property (pslverr |-> pready) else $error("slverr without ready");
  a_event_cause: assert property (|packet_event |-> (packet_event & ~$past(tx_sent | rx_stored)) == 7'h00)
    else $error("packet event without packet");
  a_event_active: assert property (|packet_event |-> (packet_event & ~$past(ep_active)) == 7'h00)
    else $error("packet event on idle endpoint");
  a_validate_win: assert property (|bank_validate |-> $past(win.write)) else $error("validate without write");
  a_validate_one: assert property (|bank_validate |-> $onehot(bank_validate)) else $error("many validates");
  a_dma_load: assert property (dma_start |=> dma_addr == $past(dma_start_addr)) else $error("dma load wrong");
  a_dma_step: assert property (dma_beat && !dma_start |=> dma_addr == $past(dma_addr) + 32'h4)
    else $error("dma address not sequential");
  a_burst_cap: assert property (1'b1 |-> dma_burst_words <= usbm_pkg::BURST_CAP_ISO) else $error("burst too long");
  a_ep0_mapped: assert property ($rose(ep_active[0]) |-> endpoint_mapped_flag[0]) else $error("ep0 active unmapped");
endmodule

bind usbm_endpoint_ram_manager usbm_endpoint_ram_manager_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .win(win), .tx_sent(tx_sent), .rx_stored(rx_stored),
  .dma_start(dma_start), .dma_start_addr(dma_start_addr), .dma_beat(dma_beat), .ep_active(ep_active),
  .endpoint_mapped_flag(endpoint_mapped_flag), .bank_validate(bank_validate), .packet_event(packet_event),
  .dma_addr(dma_addr), .dma_burst_words(dma_burst_words));

`default_nettype wire

//--- dv/usbm_host_model.sv
// bus-side partner: packet completions seen by the endpoints
// assumes the caller drives it from the pclk domain
`timescale 1ns/1ps
`default_nettype none

module usbm_host_model (
  input wire logic pclk,
  output logic [usbm_pkg::NUM_EP-1:0] tx_sent,
  output logic [usbm_pkg::NUM_EP-1:0] rx_stored
);
  initial begin
    tx_sent = '0;
    rx_stored = '0;
  end
  // status stages come as plain packets of the opposite direction
  task automatic send(input int ep, input logic in_dir, input int gap);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    if (in_dir) begin
      tx_sent <= 7'h01 << ep;
    end else begin
      rx_stored <= 7'h01 << ep;
    end
    @(posedge pclk);
    tx_sent <= '0;
    rx_stored <= '0;
  endtask
endmodule

`default_nettype wire

//--- dv/usbm_endpoint_ram_manager_tb.sv
// self-checking bench with an allocation model in integers
// assumes the design package and the host partner are compiled first
`timescale 1ns/1ps
`default_nettype none

module usbm_endpoint_ram_manager_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, bus_reset_end = 0, dma_start = 0, dma_beat = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, dma_start_addr = '0, rd, prdata, dma_addr;
  logic [2:0] dma_ep = '0;
  usbm_pkg::usbm_win_t win = '0;
  logic [usbm_pkg::NUM_EP-1:0] tx_sent, rx_stored, ep_active, mapped, bank_validate, packet_event;
  logic pready, pslverr, port_en, err;
  logic [11:0] ram_addr;
  logic [8:0] burst;
  int num_errors = 0, checked = 0, cycles = 0, len, x, s, e;
  int base[7], bk[7], code[7], ty[7], mp[7];

  usbm_endpoint_ram_manager uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_reset_end(bus_reset_end),
    .win(win), .tx_sent(tx_sent), .rx_stored(rx_stored), .dma_ep(dma_ep), .dma_start(dma_start),
    .dma_start_addr(dma_start_addr), .dma_beat(dma_beat), .device_port_enable(port_en), .ep_active(ep_active),
    .endpoint_mapped_flag(mapped), .packet_ram_addr(ram_addr), .bank_validate(bank_validate),
    .packet_event(packet_event), .dma_addr(dma_addr), .dma_burst_words(burst));
  usbm_host_model host (.pclk(pclk), .tx_sent(tx_sent), .rx_stored(rx_stored));

  initial begin
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      summarize();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  function automatic int alloc(int i);
    return bk[i] * (8 << code[i]);
  endfunction

  task automatic summarize();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // zero-wait slave, but the wait is not assumed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // this wait ends at pready; it has no limit of its own beyond the bench timeout
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic cfg(input int i, input int c, input int t, input int b);
    int old, sum;
    old = bk[i];
    bk[i] = b;
    code[i] = c;
    ty[i] = t;
    sum = 0;
    for (int k = 0; k <= i; k++) sum += alloc(k);
    if (b != 0) begin
      base[i] = (i == 0) ? 0 : base[i-1] + alloc(i-1);
      if (i < 6) base[i+1] = base[i] + alloc(i);
    end else if (old != 0 && i < 6) begin
      base[i+1] = base[i];
    end
    mp[i] = b != 0 && b <= usbm_pkg::MAX_BANKS[i] && (t != 0 || b == 1) && (i != 0 || c <= 3) && sum <= 4096;
    apb(1, 12'h100 + 12'(i * 32), 32'(b * 64 + t * 16 + c));
    apb(0, 12'h100 + 12'(i * 32), 32'h0);
    chk("cfg read", 32'(b * 64 + t * 16 + c) | (32'(mp[i]) << 31), rd);
    chk("mapped flag", 32'(mp[i]), {31'h0, mapped[i]});
  endtask

  task automatic wchk();
    for (int i = 0; i < 7; i++) begin
      if (mp[i]) begin
        @(posedge pclk);
        win <= {3'(i), 16'($urandom), 1'b0};
        repeat (2) @(posedge pclk);
        chk("ram addr", 32'((base[i] + int'(win.offset) % alloc(i)) % 4096), {20'h0, ram_addr});
      end
    end
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    void'($urandom(35));
    repeat (4) @(posedge pclk);
    presetn <= 1;
    chk("active at reset", 32'h0, {25'h0, ep_active});
    cfg(0, 3, 0, 1);
    apb(1, 12'h000, 32'h1);
    apb(1, 12'h104, 32'h1);
    repeat (3) @(posedge pclk);
    chk("port enable", 32'h1, {31'h0, port_en});
    chk("ep0 before reset end", 32'h0, {31'h0, ep_active[0]});
    bus_reset_end <= 1;
    repeat (10) @(posedge pclk);
    bus_reset_end <= 0;
    chk("ep0 active", 32'h1, {31'h0, ep_active[0]});
    cfg(1, 2, 0, 2);
    cfg(1, 7, 1, 3);
    for (x = 1; x < 6; x++) cfg(x, $urandom % 5, 1 + $urandom % 3, 1 + $urandom % usbm_pkg::MAX_BANKS[x]);
    cfg(6, 7, 1, 3);
    wchk();
    for (x = 1; x < 7; x++) begin
      len = 1 + $urandom % 2048;
      dma_ep <= 3'(x);
      apb(1, 12'h110 + 12'(x * 32), 32'(len) << 16);
      repeat (2) @(posedge pclk);
      s = (8 << code[x]) / 4;
      e = (len + 3) / 4;
      if (e < s) s = e;
      if (s > ((ty[x] == 1) ? 256 : 128)) s = (ty[x] == 1) ? 256 : 128;
      chk("burst", 32'(s), {23'h0, burst});
    end
    @(posedge pclk);
    dma_start <= 1;
    dma_start_addr <= $urandom & 32'hffff_fffc;
    @(posedge pclk);
    dma_start <= 0;
    dma_beat <= 1;
    len = 1 + $urandom % 40;
    repeat (len) @(posedge pclk);
    dma_beat <= 0;
    @(posedge pclk);
    chk("dma addr", dma_start_addr + 32'(4 * len), dma_addr);
    apb(1, 12'h124, 32'hf);
    host.send(1, 1, $urandom % 4);
    @(posedge pclk);
    chk("tx event", 32'h2, {25'h0, packet_event});
    host.send(1, 0, 0);
    @(posedge pclk);
    chk("status event", 32'h2, {25'h0, packet_event});
    @(posedge pclk);
    win <= {3'd1, 16'((8 << code[1]) - 1), 1'b1};
    @(posedge pclk);
    win <= '0;
    @(posedge pclk);
    chk("validate", 32'h2, {25'h0, bank_validate});
    apb(1, 12'h130, 32'h1);
    host.send(1, 1, 0);
    @(posedge pclk);
    chk("dma event", 32'h0, {25'h0, packet_event});
    apb(1, 12'h128, 32'h1);
    apb(0, 12'h120, 32'h0);
    chk("cfg kept", 32'(bk[1] * 64 + ty[1] * 16 + code[1]) | (32'(mp[1]) << 31), rd);
    chk("ep1 stopped", 32'h0, {31'h0, ep_active[1]});
    wchk();
    cfg(3, 0, 2, 0);
    wchk();
    cfg(3, 6, 2, 3);
    wchk();
    cfg(3, 6, 2, 0);
    cfg(3, 6, 2, 3);
    wchk();
    cfg(6, 7, 1, 3);
    apb(0, 12'h7fc, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped read", 32'h0, rd);
    summarize();
  end
endmodule

`default_nettype wire
